// File: bench/pnd_timer_model.sv
// Behavioural model of the three timer compare-match sources.
// Assumes the bench requests a pulse one cycle ahead on the same clock.
`timescale 1ns/1ns
`default_nettype none
module pnd_timer_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] req_in,
	output logic [2:0] cmp_out
);
	// Registered so that every pulse is clean and lasts exactly as long as its request.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmp_out <= 3'h0;
		end else begin
			cmp_out <= req_in;
		end
	end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the next-data buffer: register port and triggers.
// Assumes the design header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pnd_defines.svh"
module tb_top;
	logic clk, rst_n, stby, wr, rd;
	logic [2:0] req, cmp;
	logic [19:0] addr;
	logic [7:0] wd, rdata;
	logic [15:0] tp;
	int n_errors = 0;
	int total_checks = 0;
	pnd_top uut (
		.REF_CLK_IN(clk),
		.ARST_N_IN(rst_n),
		.HW_STBY_IN(stby),
		.CMP_MATCH_IN(cmp),
		.ADDR_IN(addr),
		.WDATA_IN(wd),
		.WR_IN(wr),
		.RD_IN(rd),
		.RDATA_OUT(rdata),
		.TP_OUT(tp)
	);
	pnd_timer_model tmr (
		.clk_in(clk),
		.rst_n_in(rst_n),
		.req_in(req),
		.cmp_out(cmp)
	);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr8(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// The read data stand only in the cycle after the strobe.
	task automatic rd8(input logic [19:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
	endtask
	task automatic fire(input int ch);
		@(posedge clk);
		req <= 3'h1 << ch;
		@(posedge clk);
		req <= 3'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	initial begin
		#400000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		rst_n = 1'b0;
		stby = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		req = 3'h0;
		addr = 20'h00000;
		wd = 8'h00;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd8(`PND_A_TSEL, `PND_RST_TSEL);
		rd8(`PND_A_NPA_UP, `PND_RST_NP);
		rd8(`PND_A_NPB_UP, `PND_RST_NP);
		rd8(`PND_A_NPA_LO, `PND_RSVD);
		rd8(`PND_A_NPB_LO, `PND_RSVD);
		rd8(`PND_A_POB, `PND_RST_PO);
		rd8(`PND_A_NENA, `PND_RST_NEN);
		rd8(`PND_A_NENB, `PND_RST_NEN);
		rd8(20'h00010, `PND_UNMAPPED);
		@(negedge clk);
		chk("rdata idle", 16'h0000, {8'h00, rdata});
		wr8(`PND_A_NPA_UP, 8'h3c);
		wr8(`PND_A_NPA_LO, 8'h12);
		wr8(`PND_A_NPB_UP, 8'ha5);
		wr8(`PND_A_NPB_LO, 8'h77);
		rd8(`PND_A_NPA_UP, 8'h3c);
		rd8(`PND_A_NPA_LO, 8'hff);
		rd8(`PND_A_NPB_UP, 8'ha5);
		rd8(`PND_A_NPB_LO, 8'hff);
		wr8(`PND_A_NENA, 8'hf0);
		wr8(`PND_A_NENB, 8'hff);
		rd8(`PND_A_NENA, 8'hf0);
		rd8(`PND_A_NENB, 8'hff);
		fire(1);
		chk("tp", 16'h0000, tp);
		fire(2);
		chk("tp", 16'ha530, tp);
		wr8(`PND_A_POB, 8'h00);
		rd8(`PND_A_POB, 8'ha5);
		wr8(`PND_A_NENB, 8'h0f);
		wr8(`PND_A_POB, 8'h00);
		rd8(`PND_A_POB, 8'h05);
		// Groups 0 and 1 split onto channels 0 and 1.
		wr8(`PND_A_TSEL, 8'hf4);
		rd8(`PND_A_TSEL, 8'hf4);
		rd8(`PND_A_NPA_UP, 8'h3f);
		rd8(`PND_A_NPA_LO, 8'hfc);
		wr8(`PND_A_NPA_LO, 8'h05);
		wr8(`PND_A_NPA_UP, 8'h9e);
		rd8(`PND_A_NPA_LO, 8'hf5);
		rd8(`PND_A_NPA_UP, 8'h9f);
		wr8(`PND_A_NENA, 8'hff);
		fire(0);
		chk("tp", 16'h0535, tp);
		fire(1);
		chk("tp", 16'h0595, tp);
		// Codes 10 and 11 name the same channel, so B stays shared.
		wr8(`PND_A_TSEL, 8'he4);
		rd8(`PND_A_NPB_LO, 8'hff);
		wr8(`PND_A_TSEL, 8'hc4);
		rd8(`PND_A_NPB_UP, 8'haf);
		rd8(`PND_A_NPB_LO, 8'hf5);
		wr8(`PND_A_NPB_LO, 8'h03);
		rd8(`PND_A_NPB_LO, 8'hf3);
		fire(0);
		chk("tp", 16'h0395, tp);
		@(posedge clk);
		stby <= 1'b1;
		@(posedge clk);
		stby <= 1'b0;
		@(negedge clk);
		chk("tp", 16'h0000, tp);
		rd8(`PND_A_TSEL, `PND_RST_TSEL);
		rd8(`PND_A_NPA_UP, `PND_RST_NP);
		rd8(`PND_A_NPB_UP, `PND_RST_NP);
		rd8(`PND_A_NENA, `PND_RST_NEN);
		rd8(`PND_A_NENB, `PND_RST_NEN);
		// All groups on channel 0; port A enabled bits refuse software.
		wr8(`PND_A_NPA_UP, 8'h5a);
		wr8(`PND_A_NENA, 8'hff);
		wr8(`PND_A_TSEL, 8'h00);
		fire(0);
		chk("tp", 16'h005a, tp);
		wr8(`PND_A_NENA, 8'h0f);
		wr8(`PND_A_POA, 8'hff);
		rd8(`PND_A_POA, 8'hfa);
		// A reset in mid-run must bring back every initial value.
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("tp", 16'h0000, tp);
		chk("rdata rst", 16'h0000, {8'h00, rdata});
		rd8(`PND_A_TSEL, `PND_RST_TSEL);
		rd8(`PND_A_NPA_UP, `PND_RST_NP);
		rd8(`PND_A_NENA, `PND_RST_NEN);
		rd8(`PND_A_POA, `PND_RST_PO);
		report_and_stop;
	end
endmodule
`default_nettype wire

// File: logic/pnd_defines.svh
// Addresses, reset values and fixed read patterns of the next-data buffer.
// Assumes a 20-bit byte address on the plain register port.
`ifndef PND_DEFINES_SVH
`define PND_DEFINES_SVH
`define PND_ADDR_W 20
`define PND_A_TSEL 20'hfffa1
`define PND_A_NENB 20'hfffa2
`define PND_A_NENA 20'hfffa3
`define PND_A_NPB_UP 20'hfffa4
`define PND_A_NPA_UP 20'hfffa5
`define PND_A_NPB_LO 20'hfffa6
`define PND_A_NPA_LO 20'hfffa7
`define PND_A_POA 20'hfffd9
`define PND_A_POB 20'hfffda
`define PND_RST_NP 8'h00
`define PND_RST_NEN 8'h00
`define PND_RST_TSEL 8'hff
`define PND_RST_PO 8'h00
`define PND_RSVD 8'hff
`define PND_RSVD_NIB 4'hf
`define PND_UNMAPPED 8'h00
`endif

// File: logic/pnd_out_latch.sv
// Port A and port B output latches loaded by triggers or by software.
// Assumes write strobes already decoded to a single latch address.
`timescale 1ns/1ns
`default_nettype none
`include "pnd_defines.svh"
module pnd_out_latch
	import pnd_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic hw_stby_in,
	input wire logic wr_a_in,
	input wire logic wr_b_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] ena_in,
	input wire logic [7:0] enb_in,
	input wire logic [7:0] npa_in,
	input wire logic [7:0] npb_in,
	pnd_trig_if.dst trig,
	output logic [7:0] pa_out,
	output logic [7:0] pb_out
);
	logic [7:0] pa_ff;
	logic [7:0] pb_ff;

	// Enabled bits are read-only, so a trigger copy and a software write
	// never contend for the same bit.
	function automatic logic [7:0] nxt_latch(input logic [7:0] cur,
		input logic [1:0] fire, input logic [7:0] en, input logic [7:0] nd,
		input logic wr, input logic [7:0] wd);
		logic [7:0] cp;
		logic [7:0] wm;
		cp = {{4{fire[1]}}, {4{fire[0]}}} & en;
		wm = {8{wr}} & ~en;
		return (cp & nd) | (wm & wd) | (~cp & ~wm & cur);
	endfunction

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pa_ff <= `PND_RST_PO;
		end else if (hw_stby_in) begin
			pa_ff <= `PND_RST_PO;
		end else begin
			pa_ff <= nxt_latch(pa_ff, trig.fire[1:0], ena_in, npa_in,
				wr_a_in, wdata_in); // [R3] [R16] [R19]
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pb_ff <= `PND_RST_PO;
		end else if (hw_stby_in) begin
			pb_ff <= `PND_RST_PO;
		end else begin
			pb_ff <= nxt_latch(pb_ff, trig.fire[3:2], enb_in, npb_in,
				wr_b_in, wdata_in); // [R1] [R2] [R4] [R16] [R19]
		end
	end

	assign pa_out = pa_ff;
	assign pb_out = pb_ff;
endmodule
`default_nettype wire

// File: logic/pnd_pkg.sv
// Types and the trigger decode shared by the next-data buffer modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pnd_pkg;
	typedef enum logic [1:0] {
		PND_CH0 = 2'b00,
		PND_CH1 = 2'b01,
		PND_CH2 = 2'b10
	} pnd_chan_t;
	typedef logic [3:0] pnd_grp_t;
	// Codes 10 and 11 both name timer channel 2.
	function automatic pnd_chan_t pnd_chan(input logic [1:0] sel);
		pnd_chan_t c;
		c = sel[1] ? PND_CH2 : (sel[0] ? PND_CH1 : PND_CH0);
		return c;
	endfunction
endpackage
`default_nettype wire

// File: logic/pnd_top.sv
// Next-data buffer of the timed pattern output unit: registers and trigger.
// Assumes a single-cycle register port and synchronous compare pulses.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pnd_defines.svh"
// Function
// [R1] Port B latch holds the driven pattern for groups 2 and 3.
// [R2] Port B latch bits with enable set ignore software writes.
// [R3] Group trigger copies its next_pattern_a bits into the port A latch.
// [R4] Group trigger copies its next_pattern_b bits into the port B latch.
// [R5] next_pattern_a clears on reset and hardware standby, kept otherwise.
// [R6] next_pattern_b clears on reset and hardware standby, kept otherwise.
// [R7] Groups 0 and 1 trigger sharing chooses next_pattern_a placement.
// [R8] Shared trigger: next_pattern_a whole byte at first address.
// [R9] Shared trigger: group 0/1 companion byte reads ones, ignores writes.
// [R10] Split trigger: group 1 high nibble first byte, group 0 low second.
// [R11] Split trigger: unused nibbles of both A bytes read ones, fixed.
// [R12] Shared trigger: next_pattern_b whole byte at first address.
// [R13] Shared trigger: group 2/3 companion byte reads ones, ignores writes.
// [R14] Split trigger: group 3 high nibble one byte, group 2 low other.
// [R15] Split trigger: unused nibbles of both B bytes read ones, fixed.
// [R16] Bits with enable clear are not copied; output keeps its value.
// [R17] Trigger select 00 channel 0, 01 channel 1, 1x channel 2.
// [R18] Trigger select resets to all ones, set back to all ones by hardware standby.
// [R19] Copy happens on the compare pulse edge, sharing groups together.
module pnd_top
	import pnd_pkg::*;
#(
	parameter int AW = `PND_ADDR_W
) (
	input wire logic REF_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic HW_STBY_IN,
	input wire logic [2:0] CMP_MATCH_IN,
	input wire logic [AW-1:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	output logic [15:0] TP_OUT
);
	generate
		if (AW != `PND_ADDR_W) begin : g_bad_aw
			$error("pnd_top: AW must be 20");
		end
	endgenerate

	logic [7:0] tsel_ff;
	logic [7:0] nen_a_ff;
	logic [7:0] nen_b_ff;
	logic [7:0] npa_ff;
	logic [7:0] npb_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_npa_ff;
	logic [7:0] nxt_npb_ff;
	logic [7:0] nxt_rdata_ff;
	logic [7:0] pa;
	logic [7:0] pb;

	pnd_trig_if trig ();

	pnd_trig_decode u_dec (
		.tsel_in(tsel_ff),
		.cmp_in(CMP_MATCH_IN),
		.trig(trig.src)
	);

	pnd_out_latch u_lat (
		.clk_in(REF_CLK_IN),
		.rst_n_in(ARST_N_IN),
		.hw_stby_in(HW_STBY_IN),
		.wr_a_in(WR_IN && ADDR_IN == `PND_A_POA),
		.wr_b_in(WR_IN && ADDR_IN == `PND_A_POB),
		.wdata_in(WDATA_IN),
		.ena_in(nen_a_ff),
		.enb_in(nen_b_ff),
		.npa_in(npa_ff),
		.npb_in(npb_ff),
		.trig(trig.dst),
		.pa_out(pa),
		.pb_out(pb)
	);

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			tsel_ff <= `PND_RST_TSEL;
		end else if (HW_STBY_IN) begin
			tsel_ff <= `PND_RST_TSEL; // [R18]
		end else if (WR_IN && ADDR_IN == `PND_A_TSEL) begin
			tsel_ff <= WDATA_IN;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			nen_a_ff <= `PND_RST_NEN;
			nen_b_ff <= `PND_RST_NEN;
		end else if (HW_STBY_IN) begin
			nen_a_ff <= `PND_RST_NEN;
			nen_b_ff <= `PND_RST_NEN;
		end else if (WR_IN) begin
			if (ADDR_IN == `PND_A_NENA) begin
				nen_a_ff <= WDATA_IN;
			end
			if (ADDR_IN == `PND_A_NENB) begin
				nen_b_ff <= WDATA_IN;
			end
		end
	end

	// Split-trigger placement keeps each group in its own byte so software
	// can refill one group without disturbing the other.
	always_comb begin
		nxt_npa_ff = npa_ff;
		nxt_npb_ff = npb_ff;
		if (WR_IN) begin
			unique case (ADDR_IN)
				`PND_A_NPA_UP: begin
					if (trig.same01) begin
						nxt_npa_ff = WDATA_IN; // [R8]
					end else begin
						nxt_npa_ff[7:4] = WDATA_IN[7:4]; // [R10] [R11]
					end
				end
				`PND_A_NPA_LO: begin
					if (!trig.same01) begin
						nxt_npa_ff[3:0] = WDATA_IN[3:0]; // [R10] [R11]
					end
				end
				`PND_A_NPB_UP: begin
					if (trig.same23) begin
						nxt_npb_ff = WDATA_IN; // [R12]
					end else begin
						nxt_npb_ff[7:4] = WDATA_IN[7:4]; // [R14] [R15]
					end
				end
				`PND_A_NPB_LO: begin
					if (!trig.same23) begin
						nxt_npb_ff[3:0] = WDATA_IN[3:0]; // [R14] [R15]
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			npa_ff <= `PND_RST_NP;
			npb_ff <= `PND_RST_NP;
		end else if (HW_STBY_IN) begin
			npa_ff <= `PND_RST_NP; // [R5]
			npb_ff <= `PND_RST_NP; // [R6]
		end else begin
			npa_ff <= nxt_npa_ff;
			npb_ff <= nxt_npb_ff;
		end
	end

	always_comb begin
		nxt_rdata_ff = `PND_UNMAPPED;
		if (RD_IN) begin
			unique case (ADDR_IN)
				`PND_A_TSEL: nxt_rdata_ff = tsel_ff;
				`PND_A_NENA: nxt_rdata_ff = nen_a_ff;
				`PND_A_NENB: nxt_rdata_ff = nen_b_ff;
				`PND_A_POA: nxt_rdata_ff = pa;
				`PND_A_POB: nxt_rdata_ff = pb; // [R1]
				`PND_A_NPA_UP: begin
					nxt_rdata_ff = trig.same01 ? npa_ff :
						{npa_ff[7:4], `PND_RSVD_NIB}; // [R11]
				end
				`PND_A_NPA_LO: begin
					nxt_rdata_ff = trig.same01 ? `PND_RSVD :
						{`PND_RSVD_NIB, npa_ff[3:0]}; // [R9] [R11]
				end
				`PND_A_NPB_UP: begin
					nxt_rdata_ff = trig.same23 ? npb_ff :
						{npb_ff[7:4], `PND_RSVD_NIB}; // [R15]
				end
				`PND_A_NPB_LO: begin
					nxt_rdata_ff = trig.same23 ? `PND_RSVD :
						{`PND_RSVD_NIB, npb_ff[3:0]}; // [R13] [R15]
				end
				default: nxt_rdata_ff = `PND_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rdata_ff <= `PND_UNMAPPED;
		end else begin
			rdata_ff <= nxt_rdata_ff;
		end
	end

	assign RDATA_OUT = rdata_ff;
	assign TP_OUT = {pb, pa};

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	copy_grp0_a: assert property ( // [R3]
		trig.fire[0] && !HW_STBY_IN |=>
		((TP_OUT[3:0] ^ $past(npa_ff[3:0])) & $past(nen_a_ff[3:0])) == 4'h0)
		else $error("group 0 copy missed");
	copy_grp2_a: assert property ( // [R4]
		trig.fire[2] && !HW_STBY_IN |=>
		((TP_OUT[11:8] ^ $past(npb_ff[3:0])) & $past(nen_b_ff[3:0])) == 4'h0)
		else $error("group 2 copy missed");
	lock_portb_a: assert property ( // [R2]
		WR_IN && ADDR_IN == `PND_A_POB && trig.fire[3:2] == 2'b00 &&
		!HW_STBY_IN |=>
		((TP_OUT[15:8] ^ $past(TP_OUT[15:8])) & $past(nen_b_ff)) == 8'h00)
		else $error("enabled port B bit was written");
	hold_disabled_a: assert property ( // [R16]
		trig.fire[0] && nen_a_ff[3:0] == 4'h0 && !WR_IN && !HW_STBY_IN
		|=> $stable(TP_OUT[3:0]))
		else $error("disabled bits changed on trigger");
	stby_clear_a: assert property ( // [R5]
		HW_STBY_IN |=> npa_ff == 8'h00 && npb_ff == 8'h00)
		else $error("next data not cleared in standby");
	stby_tsel_a: assert property ( // [R18]
		HW_STBY_IN |=> tsel_ff == 8'hff)
		else $error("trigger select not set in standby");
	rsvd_read_a: assert property ( // [R9]
		RD_IN && ADDR_IN == `PND_A_NPA_LO && trig.same01 |=>
		RDATA_OUT == 8'hff)
		else $error("reserved byte did not read ones");
	split_read_a: assert property ( // [R11]
		RD_IN && ADDR_IN == `PND_A_NPA_UP && !trig.same01 |=>
		RDATA_OUT[3:0] == 4'hf && RDATA_OUT[7:4] == $past(npa_ff[7:4]))
		else $error("split upper byte read wrong");
	rsvd_write_a: assert property ( // [R13]
		WR_IN && ADDR_IN == `PND_A_NPB_LO && trig.same23 && !HW_STBY_IN
		|=> $stable(npb_ff))
		else $error("reserved byte took a write");
	chan2_map_a: assert property ( // [R17]
		tsel_ff[7] |-> trig.fire[3] == CMP_MATCH_IN[2])
		else $error("group 3 not on channel 2");
	copy_grp1_a: assert property ( // [R3]
		trig.fire[1] && !HW_STBY_IN |=>
		((TP_OUT[7:4] ^ $past(npa_ff[7:4])) & $past(nen_a_ff[7:4])) == 4'h0)
		else $error("group 1 copy missed");
	copy_grp3_a: assert property ( // [R4]
		trig.fire[3] && !HW_STBY_IN |=>
		((TP_OUT[15:12] ^ $past(npb_ff[7:4])) & $past(nen_b_ff[7:4])) == 4'h0)
		else $error("group 3 copy missed");
	joint_copy_a: assert property ( // [R19]
		trig.fire[2] && trig.same23 && !HW_STBY_IN |=>
		((TP_OUT[15:8] ^ $past(npb_ff)) & $past(nen_b_ff)) == 8'h00)
		else $error("shared groups did not update together");
	stby_clear_b_a: assert property ( // [R6]
		HW_STBY_IN |=> npb_ff == 8'h00)
		else $error("next pattern b not cleared in standby");
	shared_wr_pa_a: assert property ( // [R8]
		WR_IN && ADDR_IN == `PND_A_NPA_UP && trig.same01 && !HW_STBY_IN
		|=> npa_ff == $past(WDATA_IN))
		else $error("shared byte write to pattern a lost");
	split_hi_pa_a: assert property ( // [R10]
		WR_IN && ADDR_IN == `PND_A_NPA_UP && !trig.same01 && !HW_STBY_IN
		|=> npa_ff == {$past(WDATA_IN[7:4]), $past(npa_ff[3:0])})
		else $error("split upper write to pattern a wrong");
	split_lo_pa_a: assert property ( // [R10]
		WR_IN && ADDR_IN == `PND_A_NPA_LO && !trig.same01 && !HW_STBY_IN
		|=> npa_ff == {$past(npa_ff[7:4]), $past(WDATA_IN[3:0])})
		else $error("split lower write to pattern a wrong");
	rsvd_wr_pa_a: assert property ( // [R9]
		WR_IN && ADDR_IN == `PND_A_NPA_LO && trig.same01 && !HW_STBY_IN
		|=> $stable(npa_ff))
		else $error("reserved pattern a byte took a write");
	shared_wr_pb_a: assert property ( // [R12]
		WR_IN && ADDR_IN == `PND_A_NPB_UP && trig.same23 && !HW_STBY_IN
		|=> npb_ff == $past(WDATA_IN))
		else $error("shared byte write to pattern b lost");
	split_lo_pb_a: assert property ( // [R14]
		WR_IN && ADDR_IN == `PND_A_NPB_LO && !trig.same23 && !HW_STBY_IN
		|=> npb_ff == {$past(npb_ff[7:4]), $past(WDATA_IN[3:0])})
		else $error("split lower write to pattern b wrong");
	split_read_pb_a: assert property ( // [R15]
		RD_IN && ADDR_IN == `PND_A_NPB_UP && !trig.same23 |=>
		RDATA_OUT == {$past(npb_ff[7:4]), 4'hf})
		else $error("split upper pattern b read wrong");
	rsvd_read_pb_a: assert property ( // [R13]
		RD_IN && ADDR_IN == `PND_A_NPB_LO && trig.same23 |=>
		RDATA_OUT == 8'hff)
		else $error("reserved pattern b byte did not read ones");
	split_lo_read_a: assert property ( // [R11]
		RD_IN && ADDR_IN == `PND_A_NPA_LO && !trig.same01 |=>
		RDATA_OUT == {4'hf, $past(npa_ff[3:0])})
		else $error("split lower pattern a read wrong");
	shared_read_a: assert property ( // [R8]
		RD_IN && ADDR_IN == `PND_A_NPA_UP && trig.same01 |=>
		RDATA_OUT == $past(npa_ff))
		else $error("shared pattern a read wrong");
	chan0_map_a: assert property ( // [R17]
		tsel_ff[1:0] == 2'b00 |-> trig.fire[0] == CMP_MATCH_IN[0])
		else $error("group 0 not on channel 0");
	chan1_map_a: assert property ( // [R17]
		tsel_ff[3:2] == 2'b01 |-> trig.fire[1] == CMP_MATCH_IN[1])
		else $error("group 1 not on channel 1");

	copy_seen_c: cover property (trig.fire[1] && nen_a_ff[7:4] != 4'h0);
	split_wr_c: cover property (WR_IN && ADDR_IN == `PND_A_NPB_LO &&
		!trig.same23);
	stby_seen_c: cover property (HW_STBY_IN ##1 !HW_STBY_IN);
	shared_b_c: cover property (trig.fire[2] && trig.fire[3] &&
		nen_b_ff != 8'h00);
	split_a_c: cover property (WR_IN && ADDR_IN == `PND_A_NPA_LO &&
		!trig.same01);
endmodule
`default_nettype wire

// File: logic/pnd_trig_decode.sv
// Maps the three compare-match pulses onto the four output groups.
// Assumes compare-match inputs are one-cycle pulses synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module pnd_trig_decode
	import pnd_pkg::*;
(
	input wire logic [7:0] tsel_in,
	input wire logic [2:0] cmp_in,
	pnd_trig_if.src trig
);
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			trig.fire[g] = cmp_in[pnd_chan(tsel_in[2*g +: 2])]; // [R17]
		end
		trig.same01 = pnd_chan(tsel_in[1:0]) == pnd_chan(tsel_in[3:2]); // [R7]
		trig.same23 = pnd_chan(tsel_in[5:4]) == pnd_chan(tsel_in[7:6]);
	end
endmodule
`default_nettype wire

// File: logic/pnd_trig_if.sv
// Per-group copy strobes and shared-trigger flags between decoder and latch.
// Assumes one clock domain; all signals are combinational levels.
`timescale 1ns/1ns
`default_nettype none
interface pnd_trig_if;
	logic [3:0] fire;
	logic same01;
	logic same23;
	modport src (output fire, output same01, output same23);
	modport dst (input fire, input same01, input same23);
endinterface
`default_nettype wire
